// ===== bgpm_pkg.sv
// Constants, register map and carrier types of the button GPIO port.
// Assumes a 50 MHz system clock and 32-bit Avalon-MM register access.
`default_nettype none

package bgpm_pkg;

    localparam int NPIN = 10;

    // Byte offsets of the registers
    localparam logic [5:0] OFS_DATA0 = 6'h00;
    localparam logic [5:0] OFS_DATA1 = 6'h04;
    localparam logic [5:0] OFS_DRV0 = 6'h08;
    localparam logic [5:0] OFS_DRV1 = 6'h0C;
    localparam logic [5:0] OFS_CTRL = 6'h10;
    localparam logic [5:0] OFS_SET = 6'h14;
    localparam logic [5:0] OFS_PIN_IN = 6'h18;
    localparam logic [5:0] OFS_IRQ_ST = 6'h1C;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h20;

    // Option control register fields
    localparam int CTRL_STROBE = 7;
    localparam int CTRL_MATRIX = 6;
    localparam int CTRL_ROFF = 5;
    localparam int CTRL_LED = 0;
    // Clock output enables in the special-role register
    localparam int SET_CLK4 = 0;
    localparam int SET_CLK6 = 1;

    // Pin role masks
    localparam logic [9:0] MATRIX_PINS = 10'h00E;
    localparam logic [9:0] ROFF_PINS = 10'h006;
    localparam logic [9:0] SMALL_PINS = 10'h03F;
    localparam logic [9:0] LED_PIN = 10'h020;

    // Latches reset to all ones in open-drain mode
    localparam logic [9:0] RST_DATA = 10'h3FF;
    localparam logic [9:0] RST_DRV = 10'h000;

    // Auxiliary clock output half period in system clocks
    localparam int CLKOUT_HALF = 12;

    typedef struct packed {
        logic [9:0] data;
        logic [9:0] drv;
        logic mtx_pend;
        logic roff_pend;
        logic strobe;
        logic [1:0] led;
        logic [1:0] clken;
        logic [9:0] irq_st;
        logic [9:0] irq_mask;
        logic [9:0] pin_prev;
        logic ack;
        logic [31:0] rdata;
        logic [15:0] div_cnt;
        logic clk_out;
    } bgpm_state_s;

    localparam bgpm_state_s ST_RST = '{data: RST_DATA, drv: RST_DRV, default: '0};

    typedef struct packed {
        logic [9:0] out;
        logic [9:0] oe_n;
        logic [9:0] pullup_en;
        logic [9:0] pulldown_en;
    } bgpm_pad_s;

endpackage

`default_nettype wire

// ===== bgpm_port.sv
// Button GPIO port: drive modes, pad option latches, LED sink, clock out, wake.
// Assumes synchronous pin inputs and a pad supply reset separate from core reset.
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`default_nettype none

// Functional notes
// [R01] Per-pin open-drain or push-pull drive bit
// [R02] Small package six pins, large ten
// [R03] Matrix on pins 3:1, pullup-off 2:1
// [R04] Pin 0 input only, never driven
// [R05] Pin 5 only an LED sink
// [R06] LED off during a debug session
// [R07] Clock output on pin 4, 6 or both
// [R08] Pullup-off latched in pad, survives shutdown
// [R09] Grounded input in shutdown requests wake
// [R10] Matrix latch grounds pins 3:1 in shutdown
// [R11] Matrix drops pullups, enables pulldowns 3:1
// [R12] Software latches matrix with pullup-off zero
// [R13] Software sets rows open-drain inputs first
// [R14] Firmware clears matrix before scanning
// [R15] Firmware scans rows one-cold 110,101,011,111
// [R16] Matrix three rows by two or six
// [R17] Strobe 0-1-0 latches matrix and pullup-off
// [R18] Control read returns latched option values
// [R19] Wake is asynchronous OR of low inputs
module bgpm_port #(
    parameter bit LARGE_PKG = 1'b1,
    parameter int CLK_HALF = bgpm_pkg::CLKOUT_HALF
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pad_rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [9:0] pin_in,
    input wire logic shutdown,
    input wire logic debug_active,
    output bgpm_pkg::bgpm_pad_s pad,
    output logic led_sink_en,
    output logic [1:0] led_level,
    output logic wake_req,
    output logic irq
);

    bgpm_pkg::bgpm_state_s s_q;
    bgpm_pkg::bgpm_state_s s_d;
    logic mtx_lat_q;
    logic roff_lat_q;
    logic strobe_fall;
    logic acc;
    logic [9:0] present;
    logic [9:0] wake_cap;
    logic [9:0] pin_m;
    logic [9:0] p_out;
    logic [9:0] p_oe_n;
    logic [9:0] p_pu;
    logic [9:0] p_pd;

    assign present = LARGE_PKG ? 10'h3FF : bgpm_pkg::SMALL_PINS; // R02
    assign pin_m = pin_in & present;
    // Rows held low by the matrix latch would wake forever, so they are left out
    assign wake_cap = present & ~bgpm_pkg::LED_PIN
        & ~(mtx_lat_q ? bgpm_pkg::MATRIX_PINS : 10'h000);
    assign wake_req = shutdown && |(~pin_m & wake_cap); // R09 R19

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
        input logic [1:0] be);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register file and core state

    always_comb begin
        logic [9:0] clr;
        logic [15:0] w16;
        clr = '0;
        s_d = s_q;
        strobe_fall = 1'b0;
        acc = (avs_read || avs_write) && s_q.ack;
        s_d.ack = (avs_read || avs_write) && !s_q.ack;
        w16 = 16'h0000;
        if (s_d.ack) begin
            s_d.rdata = '0;
            if (avs_address == bgpm_pkg::OFS_DATA0) begin
                s_d.rdata[7:0] = s_q.data[7:0];
            end else if (avs_address == bgpm_pkg::OFS_DATA1 && LARGE_PKG) begin
                s_d.rdata[1:0] = s_q.data[9:8];
            end else if (avs_address == bgpm_pkg::OFS_DRV0) begin
                s_d.rdata[7:0] = s_q.drv[7:0];
            end else if (avs_address == bgpm_pkg::OFS_DRV1 && LARGE_PKG) begin
                s_d.rdata[1:0] = s_q.drv[9:8];
            end else if (avs_address == bgpm_pkg::OFS_CTRL) begin
                s_d.rdata[bgpm_pkg::CTRL_STROBE] = s_q.strobe;
                s_d.rdata[bgpm_pkg::CTRL_MATRIX] = mtx_lat_q; // R18
                s_d.rdata[bgpm_pkg::CTRL_ROFF] = roff_lat_q; // R18
                s_d.rdata[bgpm_pkg::CTRL_LED +: 2] = s_q.led;
            end else if (avs_address == bgpm_pkg::OFS_SET) begin
                s_d.rdata[1:0] = s_q.clken;
            end else if (avs_address == bgpm_pkg::OFS_PIN_IN) begin
                s_d.rdata[9:0] = pin_m & ~bgpm_pkg::LED_PIN;
            end else if (avs_address == bgpm_pkg::OFS_IRQ_ST) begin
                s_d.rdata[9:0] = s_q.irq_st;
            end else if (avs_address == bgpm_pkg::OFS_IRQ_MASK) begin
                s_d.rdata[9:0] = s_q.irq_mask;
            end
        end
        if (acc && avs_write) begin
            if (avs_address == bgpm_pkg::OFS_DATA0) begin
                w16 = merge({8'h00, s_q.data[7:0]}, avs_writedata[15:0], avs_byteenable[1:0]);
                s_d.data[7:0] = w16[7:0];
            end else if (avs_address == bgpm_pkg::OFS_DATA1 && LARGE_PKG) begin
                w16 = merge({14'h0000, s_q.data[9:8]}, avs_writedata[15:0], avs_byteenable[1:0]);
                s_d.data[9:8] = w16[1:0];
            end else if (avs_address == bgpm_pkg::OFS_DRV0) begin
                w16 = merge({8'h00, s_q.drv[7:0]}, avs_writedata[15:0], avs_byteenable[1:0]);
                s_d.drv[7:0] = w16[7:0]; // R01
            end else if (avs_address == bgpm_pkg::OFS_DRV1 && LARGE_PKG) begin
                w16 = merge({14'h0000, s_q.drv[9:8]}, avs_writedata[15:0], avs_byteenable[1:0]);
                s_d.drv[9:8] = w16[1:0]; // R01
            end else if (avs_address == bgpm_pkg::OFS_CTRL && avs_byteenable[0]) begin
                // The pad takes the options on the falling edge of the strobe bit
                strobe_fall = s_q.strobe && !avs_writedata[bgpm_pkg::CTRL_STROBE]; // R17
                s_d.strobe = avs_writedata[bgpm_pkg::CTRL_STROBE];
                s_d.mtx_pend = avs_writedata[bgpm_pkg::CTRL_MATRIX];
                s_d.roff_pend = avs_writedata[bgpm_pkg::CTRL_ROFF];
                s_d.led = avs_writedata[bgpm_pkg::CTRL_LED +: 2];
            end else if (avs_address == bgpm_pkg::OFS_SET && avs_byteenable[0]) begin
                s_d.clken = avs_writedata[1:0]; // R07
            end else if (avs_address == bgpm_pkg::OFS_IRQ_MASK) begin
                w16 = merge({6'h00, s_q.irq_mask}, avs_writedata[15:0], avs_byteenable[1:0]);
                s_d.irq_mask = w16[9:0];
            end
        end
        if (acc && avs_read && avs_address == bgpm_pkg::OFS_IRQ_ST) begin
            clr = s_q.irq_st;
        end
        // A press arriving with the clearing read still sets its bit
        s_d.irq_st = (s_q.irq_st & ~clr) | (s_q.pin_prev & ~pin_m & wake_cap);
        s_d.pin_prev = pin_m;
        if (s_q.clken == 2'b00) begin
            s_d.div_cnt = '0;
            s_d.clk_out = 1'b0;
        end else if (s_q.div_cnt == 16'(CLK_HALF - 1)) begin
            s_d.div_cnt = '0;
            s_d.clk_out = !s_q.clk_out;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= bgpm_pkg::ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Option latches sit in the pad supply, so core reset leaves them alone
    always_ff @(posedge sys_clk or negedge pad_rst_n) begin
        if (!pad_rst_n) begin
            mtx_lat_q <= 1'b0;
            roff_lat_q <= 1'b0;
        end else if (strobe_fall) begin
            mtx_lat_q <= s_d.mtx_pend; // R17
            roff_lat_q <= s_d.roff_pend; // R08
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
    assign avs_readdata = s_q.rdata;
    assign irq = |(s_q.irq_st & s_q.irq_mask);
    assign led_level = s_q.led;
    assign led_sink_en = (s_q.led != 2'b00) && !debug_active && !shutdown; // R05 R06

    ////////////////////////////////////////////////////////////////////////////////
    // Pad control per pin

    for (genvar gi = 0; gi < bgpm_pkg::NPIN; gi++) begin : g_pin
        localparam bit APP = (gi < 6 || LARGE_PKG) && gi != 0 && gi != 5; // R02 R04 R05
        logic clk_role;
        assign clk_role = (gi == 4 && s_q.clken[bgpm_pkg::SET_CLK4])
            || (gi == 6 && s_q.clken[bgpm_pkg::SET_CLK6]); // R07
        assign p_out[gi] = !shutdown && APP
            && (clk_role ? s_q.clk_out : (s_q.drv[gi] && s_q.data[gi])); // R01
        // Open drain: enable only while the latch holds zero
        assign p_oe_n[gi] = shutdown ? !(bgpm_pkg::MATRIX_PINS[gi] && mtx_lat_q) // R10
            : (!APP ? 1'b1 : ((clk_role || s_q.drv[gi]) ? 1'b0 : s_q.data[gi])); // R01
        assign p_pu[gi] = present[gi] && !(bgpm_pkg::ROFF_PINS[gi] && roff_lat_q) // R03 R08
            && !(bgpm_pkg::MATRIX_PINS[gi] && mtx_lat_q); // R11
        assign p_pd[gi] = bgpm_pkg::MATRIX_PINS[gi] && mtx_lat_q; // R03 R11
    end

    assign pad = '{out: p_out, oe_n: p_oe_n, pullup_en: p_pu, pulldown_en: p_pd};

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence ctrl_wr_s(bit sv);
        avs_write && !avs_waitrequest && avs_address == bgpm_pkg::OFS_CTRL
            && avs_byteenable[0] && avs_writedata[bgpm_pkg::CTRL_STROBE] == sv;
    endsequence

    // Only a clearing write that follows a set strobe may move the pad latches
    sequence strobe_drop_s;
        ctrl_wr_s(1'b0) ##0 s_q.strobe;
    endsequence

    sequence ctrl_rd_s;
        avs_read && avs_waitrequest && avs_address == bgpm_pkg::OFS_CTRL;
    endsequence

    pin0_input_only_a: assert property (pad.oe_n[0] && !pad.out[0]) // R04
        else $error("pin 0 driven");
    led_pin_free_a: assert property (pad.oe_n[5]) // R05
        else $error("pin 5 driven as output");
    led_debug_off_a: assert property (debug_active |-> !led_sink_en) // R06
        else $error("LED on during debug");
    small_pkg_a: assert property (LARGE_PKG || (&pad.oe_n[9:6] && pad.pullup_en[9:6] == 4'h0)) // R02
        else $error("absent pin active");
    option_scope_a: assert property (pad.pulldown_en[9:4] == 6'h00 && !pad.pulldown_en[0]
        && pad.pullup_en[3] == !mtx_lat_q) // R03
        else $error("option outside its pins");
    od_drive_a: assert property (!shutdown && !s_q.drv[1] |-> pad.oe_n[1] == s_q.data[1]
        && !pad.out[1]) // R01
        else $error("open drain drive wrong");
    clk_pins_a: assert property (!shutdown && LARGE_PKG && s_q.clken == 2'b11
        |-> pad.out[4] == pad.out[6] && !pad.oe_n[4] && !pad.oe_n[6]) // R07
        else $error("clock output missing");
    clk_toggle_a: assert property (s_q.clken != 2'b00 && $stable(s_q.clken)
        && s_q.div_cnt == 16'(CLK_HALF - 1) |=> s_q.clk_out != $past(s_q.clk_out)) // R07
        else $error("clock output not toggling");
    roff_pull_a: assert property (roff_lat_q |-> pad.pullup_en[2:1] == 2'b00) // R08
        else $error("pullups kept with option set");
    matrix_pull_a: assert property (shutdown && mtx_lat_q
        |-> pad.oe_n[3:1] == 3'b000 && pad.out[3:1] == 3'b000) // R10
        else $error("matrix rows not grounded");
    matrix_pads_a: assert property (mtx_lat_q
        |-> pad.pullup_en[3:1] == 3'b000 && pad.pulldown_en[3:1] == 3'b111) // R11
        else $error("matrix pulls wrong");
    wake_low_a: assert property (shutdown && !pin_in[4] |-> wake_req) // R09 R19
        else $error("no wake on low input");
    strobe_latch_a: assert property (strobe_drop_s
        |=> mtx_lat_q == $past(avs_writedata[bgpm_pkg::CTRL_MATRIX])
        && roff_lat_q == $past(avs_writedata[bgpm_pkg::CTRL_ROFF])) // R17
        else $error("option latch missed strobe");
    strobe_hold_a: assert property (ctrl_wr_s(1'b0) ##0 !s_q.strobe
        |=> $stable(mtx_lat_q) && $stable(roff_lat_q)) // R17
        else $error("option latch moved without strobe");
    ctrl_read_a: assert property (ctrl_rd_s ##1 !avs_waitrequest
        |-> avs_readdata[bgpm_pkg::CTRL_MATRIX] == mtx_lat_q
        && avs_readdata[bgpm_pkg::CTRL_ROFF] == roff_lat_q) // R18
        else $error("control read not latch value");

endmodule

`default_nettype wire

// ===== bgpm_pins.sv
// Model of push buttons, a 3x2 key matrix and pad pulls at the pins.
// Assumes the pad struct of the port; matrix columns sit on pins 0 and 4.
`default_nettype none
module bgpm_pins (
    input wire logic sys_clk,
    input wire bgpm_pkg::bgpm_pad_s pad,
    input wire logic [9:0] btn,
    input wire logic [5:0] mtx,
    output logic [9:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] lvl;
    logic ph = 1'b0;
    always @(posedge sys_clk) ph <= ~ph;
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            if (!pad.oe_n[i]) lvl[i] = pad.out[i];
            else if (btn[i]) lvl[i] = 1'b0;
            else if (pad.pullup_en[i]) lvl[i] = 1'b1;
            else if (pad.pulldown_en[i]) lvl[i] = 1'b0;
            // A floating pin must not settle to a lucky constant
            else lvl[i] = ph ^ i[0];
        end
        pin_in = lvl;
        for (int r = 0; r < 3; r++) begin
            for (int c = 0; c < 2; c++) begin
                if (mtx[r*2+c]) begin
                    pin_in[r+1] = pin_in[r+1] & lvl[c*4];
                    pin_in[c*4] = pin_in[c*4] & lvl[r+1];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== button_gpio_port_matrix_wake_bench.sv
// Self-checking bench of the button GPIO port with a pin model.
// Assumes the register map and one-wait-state bus of the port.
`default_nettype none
module button_gpio_port_matrix_wake_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pad_rst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, led_sink_en, wake_req, irq;
    logic [1:0] led_level;
    logic [9:0] pin_in, dt, dv, v0, eo, eout;
    logic shutdown = 1'b0;
    logic debug_active = 1'b0;
    logic [9:0] btn = 10'h000;
    logic [5:0] mtx = 6'h00;
    bgpm_pkg::bgpm_pad_s pad;
    logic [63:0] exp_q[$];
    logic [63:0] e;
    logic [2:0] pats [4] = '{3'b110, 3'b101, 3'b011, 3'b111};
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    integer seed = 35230;

    always #10 sys_clk = ~sys_clk;

    bgpm_port #(.LARGE_PKG(1'b1), .CLK_HALF(2)) i_bgpm_port (.sys_clk(sys_clk), .rst_n(rst_n),
        .pad_rst_n(pad_rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
        .shutdown(shutdown), .debug_active(debug_active), .pad(pad),
        .led_sink_en(led_sink_en), .led_level(led_level), .wake_req(wake_req), .irq(irq));
    bgpm_pins i_bgpm_pins (.sys_clk(sys_clk), .pad(pad), .btn(btn), .mtx(mtx), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] ex, input string msg);
        cmp_count++;
        if (got !== ex) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, ex);
        end
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    // Read data are taken at the rising edge that sees waitrequest low
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            e = exp_q.pop_front();
            chk(avs_readdata & e[63:32], e[31:0], "read data");
        end
    end
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= wd;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge sys_clk);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] ex, input logic [31:0] m);
        exp_q.push_back({m, ex & m});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic latch_opt(input logic mx, input logic ro);
        wr(bgpm_pkg::OFS_CTRL, {25'h0, mx, ro, 5'h00});
        wr(bgpm_pkg::OFS_CTRL, {24'h0, 1'b1, mx, ro, 5'h00});
        wr(bgpm_pkg::OFS_CTRL, {25'h0, mx, ro, 5'h00});
    endtask
    task automatic wr_port(input logic [9:0] d, input logic [9:0] v);
        wr(bgpm_pkg::OFS_DATA0, {24'h0, d[7:0]});
        wr(bgpm_pkg::OFS_DATA1, {30'h0, d[9:8]});
        wr(bgpm_pkg::OFS_DRV0, {24'h0, v[7:0]});
        wr(bgpm_pkg::OFS_DRV1, {30'h0, v[9:8]});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        pad_rst_n <= 1'b1;
        rd(bgpm_pkg::OFS_DATA0, 32'hFF, 32'hFF);
        rd(bgpm_pkg::OFS_DATA1, 32'h3, 32'h3);
        rd(bgpm_pkg::OFS_CTRL, 32'h0, 32'h60);
        chk(32'(pad.oe_n), 32'h3FF, "reset enables");
        for (int k = 0; k < 6; k++) begin
            dt = 10'($random(seed));
            dv = 10'($random(seed));
            wr_port(dt, dv);
            @(negedge sys_clk);
            for (int i = 0; i < 10; i++) begin
                eo[i] = (i == 0 || i == 5) ? 1'b1 : (dv[i] ? 1'b0 : dt[i]);
                eout[i] = ~eo[i] & dt[i];
            end
            chk(32'(pad.oe_n), 32'(eo), "drive enables");
            chk(32'(pad.out & ~pad.oe_n), 32'(eout), "driven levels");
        end
        wr_port(10'h3FF, 10'h000);
        wr(bgpm_pkg::OFS_CTRL, 32'h40);
        rd(bgpm_pkg::OFS_CTRL, 32'h0, 32'h60);
        latch_opt(1'b1, 1'b0);
        rd(bgpm_pkg::OFS_CTRL, 32'h40, 32'h60);
        chk(32'(pad.pullup_en & 10'h00E), 32'h0, "matrix pullups");
        chk(32'(pad.pulldown_en), 32'h00E, "matrix pulldowns");
        shutdown <= 1'b1;
        @(negedge sys_clk);
        chk(32'(pad.oe_n & 10'h00E), 32'h0, "rows grounded");
        chk(32'(wake_req), 32'h0, "idle wake");
        @(posedge sys_clk);
        mtx <= 6'h02;
        @(negedge sys_clk);
        chk(32'(wake_req), 32'h1, "matrix wake");
        @(posedge sys_clk);
        mtx <= 6'h00;
        shutdown <= 1'b0;
        latch_opt(1'b0, 1'b0);
        mtx <= 6'h20;
        for (int k = 0; k < 4; k++) begin
            wr(bgpm_pkg::OFS_DATA0, {24'h0, 4'hF, pats[k], 1'b1});
            repeat (3) @(posedge sys_clk);
            rd(bgpm_pkg::OFS_PIN_IN, 32'(pats[k][2]) << 4, 32'h10);
        end
        mtx <= 6'h00;
        latch_opt(1'b0, 1'b1);
        // The latch loads at the edge that ends the write, so look after it settles
        @(negedge sys_clk);
        chk(32'(pad.pullup_en & 10'h00E), 32'h008, "pullup off");
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        // Core reset must leave the pad latches alone
        rd(bgpm_pkg::OFS_CTRL, 32'h20, 32'h60);
        latch_opt(1'b0, 1'b0);
        wr(bgpm_pkg::OFS_CTRL, 32'h2);
        @(negedge sys_clk);
        chk({29'h0, led_sink_en, led_level}, 32'h6, "led on");
        @(posedge sys_clk);
        debug_active <= 1'b1;
        @(negedge sys_clk);
        chk(32'(led_sink_en), 32'h0, "led in debug");
        @(posedge sys_clk);
        debug_active <= 1'b0;
        for (int s = 1; s < 4; s++) begin
            wr(bgpm_pkg::OFS_SET, 32'(s));
            @(negedge sys_clk);
            v0 = pad.out;
            chk(32'(pad.oe_n & 10'h050), 32'(10'h050 & ~{3'h0, s[1], 1'b0, s[0], 4'h0}), "clk en");
            repeat (2) @(negedge sys_clk);
            chk(32'((pad.out ^ v0) & 10'h050), 32'({3'h0, s[1], 1'b0, s[0], 4'h0}), "clk toggle");
        end
        wr(bgpm_pkg::OFS_SET, 32'h0);
        rd(bgpm_pkg::OFS_IRQ_ST, 32'h0, 32'h0);
        rd(bgpm_pkg::OFS_IRQ_ST, 32'h0, 32'h180);
        wr(bgpm_pkg::OFS_IRQ_MASK, 32'h080);
        btn <= 10'h180;
        repeat (4) @(negedge sys_clk);
        chk(32'(irq), 32'h1, "irq raised");
        rd(bgpm_pkg::OFS_IRQ_ST, 32'h180, 32'h180);
        btn <= 10'h000;
        @(negedge sys_clk);
        chk(32'(irq), 32'h0, "irq cleared");
        wr(bgpm_pkg::OFS_IRQ_MASK, 32'h0);
        btn <= 10'h100;
        repeat (4) @(negedge sys_clk);
        chk(32'(irq), 32'h0, "irq masked");
        @(posedge sys_clk);
        btn <= 10'h000;
        rd(6'h3C, 32'h0, 32'hFFFFFFFF);
        give_verdict();
    end
endmodule
`default_nettype wire
